// file: hw/balex_core.sv
// execute unit for byte add, subtract, and, inclusive-or in all addressing forms
// assumes program memory answers mem_rd_o with data on mem_data_i one clock later
// Overview of operation
// RQ1 - absolute add sums memory byte into r
// RQ2 - absolute forms take twelve clocks
// RQ3 - register and immediate forms take six clocks
// RQ4 - relative forms take nine clocks
// RQ5 - indexing: low opcode bits pick index, r0 destination
// RQ6 - subtract adds two's complement of subtrahend
// RQ7 - register subtract: r0 minus r into r0
// RQ8 - immediate subtract: r minus second byte
// RQ9 - relative/absolute subtract: r minus memory byte
// RQ10 - add updates flags, optional carry in
// RQ11 - subtract updates flags, optional borrow in
// RQ12 - condition code positive 01, zero 00, negative 10
// RQ13 - register and: r0 and r into r0, cc only
// RQ14 - other and forms: r and operand into r
// RQ15 - opcode 01000000 is halt, not and
// RQ16 - register or: r0 or r into r0
// RQ17 - subtract allows single-level indirect addressing
// RQ18 - relative address is next byte plus displacement
// RQ19 - indirect pointer is fifteen bits, top ignored
// RQ20 - carry bit7, interdigit bit3, overflow sign error
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module balex_core import balex_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [14:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [7:0] mem_data_i
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_READ = 5'b00010,
        S_CAPT = 5'b00100,
        S_EXEC = 5'b01000,
        S_PAD = 5'b10000
    } balex_state_t;

    typedef enum logic [5:0] {
        ST_OP = 6'b000001,
        ST_B1 = 6'b000010,
        ST_B2 = 6'b000100,
        ST_PH = 6'b001000,
        ST_PL = 6'b010000,
        ST_DAT = 6'b100000
    } balex_stage_t;

    balex_state_t state;
    balex_stage_t stage;
    logic [7:0] rf [4];
    balex_flags_t psw;
    logic [14:0] pc;
    logic [14:0] ea;
    logic [7:0] ir0;
    logic [7:0] ir1;
    logic [7:0] ptr_hi;
    logic [7:0] opnd;
    logic [4:0] cyc;
    logic [4:0] budget;
    logic [1:0] len;
    logic done;
    logic halted;
    logic illegal;
    logic resp;

    logic acc;
    logic wr_go;
    logic busy;
    logic [3:0] cls;
    logic [1:0] mode;
    logic [1:0] rsel;
    logic indexed;
    logic legal;
    logic [1:0] dst;
    logic [7:0] a_opd;
    logic [7:0] b_opd;
    balex_op_t op;
    balex_res_t res;

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] nw,
                                              input logic en);
        return en ? nw : old;
    endfunction

    // bus handshake: answer on the second edge of every request
    assign acc = (avs_read_i | avs_write_i) & resp;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp;
    assign busy = (state != S_IDLE);
    assign wr_go = acc & avs_write_i & (avs_address_i == OFS_CTRL) & avs_byteenable_i[0]
                   & avs_writedata_i[CTRL_GO] & ~busy;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            resp <= 1'b0;
        end else begin
            resp <= (avs_read_i | avs_write_i) & ~resp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if ((avs_read_i | avs_write_i) & ~resp) begin
            avs_readdata_o <= 32'h0000_0000;
            unique case (avs_address_i)
                OFS_STAT: avs_readdata_o[3:0] <= {illegal, halted, done, busy};
                OFS_PC: avs_readdata_o[14:0] <= pc;
                OFS_PSW: avs_readdata_o[7:0] <= {psw.cc, psw.interdigit_carry_flag, 1'b0, psw.wc, psw.ovf, 1'b0,
                                                 psw.c};
                OFS_R0, OFS_R0 + 5'h04, OFS_R0 + 5'h08, OFS_R0 + 5'h0c:
                    avs_readdata_o[7:0] <= rf[avs_address_i[3:2]];
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // opcode fields
    assign cls = ir0[7:4];
    assign mode = ir0[3:2];
    assign rsel = ir0[1:0];
    assign indexed = (mode == MODE_A) && (ir1[6:5] != 2'b00);
    assign legal = (ir0 != HALT_CODE) && // [RQ15]
                   (cls == CLS_AND || cls == CLS_IOR || cls == CLS_ADD || cls == CLS_SUB);

    always_comb begin
        unique case (cls)
            CLS_AND: op = OP_AND;
            CLS_IOR: op = OP_IOR;
            CLS_SUB: op = OP_SUB;
            default: op = OP_ADD;
        endcase
        // register forms work into r0; indexed absolute redirects the result to r0 [RQ5]
        dst = (mode == MODE_Z || indexed) ? 2'd0 : rsel; // [RQ7] [RQ13] [RQ16]
        a_opd = rf[dst]; // minuend is the destination [RQ7] [RQ8] [RQ9]
        unique case (mode)
            MODE_Z: b_opd = rf[rsel];
            MODE_I: b_opd = ir1; // [RQ8] [RQ14]
            default: b_opd = opnd; // [RQ1] [RQ9] [RQ14]
        endcase
        unique case (stage)
            ST_OP: mem_addr_o = pc;
            ST_B1: mem_addr_o = pc + 15'd1;
            ST_B2: mem_addr_o = pc + 15'd2;
            ST_PL: mem_addr_o = ea + 15'd1;
            default: mem_addr_o = ea;
        endcase
    end

    assign mem_rd_o = (state == S_READ);

    balex_alu u_alu (
        .op_i(op),
        .a_i(a_opd),
        .b_i(b_opd),
        .flags_i(psw),
        .res_o(res)
    );

    // sequencer: fetch bytes, resolve address, execute, pad to the documented time
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= S_IDLE;
            stage <= ST_OP;
            cyc <= 5'd0;
            budget <= BUD_REG;
            len <= 2'd1;
            ir0 <= 8'h00;
            ir1 <= 8'h00;
            ptr_hi <= 8'h00;
            opnd <= 8'h00;
            ea <= 15'h0000;
        end else begin
            cyc <= busy ? cyc + 5'd1 : 5'd0;
            unique case (state)
                S_IDLE: begin
                    if (wr_go) begin
                        state <= S_READ;
                        stage <= ST_OP;
                    end
                end
                S_READ: state <= S_CAPT;
                S_CAPT: begin
                    state <= S_READ;
                    unique case (stage)
                        ST_OP: begin
                            ir0 <= mem_data_i;
                            unique case (mem_data_i[3:2])
                                MODE_Z: begin
                                    budget <= BUD_REG; // [RQ3]
                                    len <= 2'd1;
                                    state <= S_EXEC;
                                end
                                MODE_I: begin
                                    budget <= BUD_REG; // [RQ3]
                                    len <= 2'd2;
                                end
                                MODE_R: begin
                                    budget <= BUD_REL; // [RQ4]
                                    len <= 2'd2;
                                end
                                default: begin
                                    budget <= BUD_ABS; // [RQ2]
                                    len <= 2'd3;
                                end
                            endcase
                            stage <= ST_B1;
                        end
                        ST_B1: begin
                            ir1 <= mem_data_i;
                            if (mode == MODE_I) begin
                                state <= S_EXEC;
                            end else if (mode == MODE_R) begin
                                // displacement is relative to the byte after the instruction
                                ea <= pc + 15'd2 + {{8{mem_data_i[6]}}, mem_data_i[6:0]}; // [RQ18]
                                stage <= mem_data_i[IND_BIT] ? ST_PH : ST_DAT; // [RQ17]
                            end else begin
                                stage <= ST_B2;
                            end
                            // an immediate byte has no indirect flag, so bit 7 must not stretch it
                            if (mem_data_i[IND_BIT] && mode != MODE_I) begin
                                budget <= budget + BUD_IND; // [RQ3] [RQ17]
                            end
                        end
                        ST_B2: begin
                            // index is added after the pointer when indirect [RQ5]
                            if (ir1[IND_BIT] || !indexed) begin
                                ea <= {ir1[4:0], mem_data_i} + 15'd0;
                            end else begin
                                ea <= {ir1[4:0], mem_data_i} + {7'h00, rf[rsel]}; // [RQ5]
                            end
                            stage <= ir1[IND_BIT] ? ST_PH : ST_DAT; // [RQ17]
                        end
                        ST_PH: begin
                            ptr_hi <= mem_data_i;
                            stage <= ST_PL;
                        end
                        ST_PL: begin
                            // single level only: the pointer target is the operand address
                            ea <= {ptr_hi[6:0], mem_data_i}
                                  + (indexed ? {7'h00, rf[rsel]} : 15'd0); // [RQ19]
                            stage <= ST_DAT;
                        end
                        default: begin
                            opnd <= mem_data_i;
                            state <= S_EXEC;
                        end
                    endcase
                end
                S_EXEC: state <= S_PAD;
                default: begin
                    if (cyc == budget - 5'd1) begin // [RQ2] [RQ3] [RQ4]
                        state <= S_IDLE;
                        stage <= ST_OP;
                    end
                end
            endcase
        end
    end

    // architectural state: results commit once, in the execute cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 4; i++) begin
                rf[i] <= 8'h00;
            end
            psw <= balex_flags_t'(6'h00);
            pc <= PC_RESET;
        end else if (state == S_EXEC) begin
            if (legal) begin
                rf[dst] <= res.data; // [RQ1] [RQ7] [RQ8] [RQ9] [RQ13] [RQ14] [RQ16]
                psw <= res.flags; // [RQ10] [RQ11] [RQ12]
            end
        end else if (state == S_PAD && cyc == budget - 5'd1) begin
            pc <= pc + {13'h0000, len};
        end else if (acc && avs_write_i && !busy) begin
            if (avs_address_i == OFS_PC) begin
                pc[7:0] <= lane_merge(pc[7:0], avs_writedata_i[7:0], avs_byteenable_i[0]);
                pc[14:8] <= 7'(lane_merge({1'b0, pc[14:8]}, avs_writedata_i[15:8],
                                          avs_byteenable_i[1]));
            end
            if (avs_address_i == OFS_PSW && avs_byteenable_i[0]) begin
                psw.c <= avs_writedata_i[PSW_C];
                psw.ovf <= avs_writedata_i[PSW_OVF];
                psw.wc <= avs_writedata_i[PSW_WC];
                psw.interdigit_carry_flag <= avs_writedata_i[PSW_IDC];
                psw.cc <= avs_writedata_i[PSW_CCHI:PSW_CCLO];
            end
            if (avs_address_i[4] && avs_byteenable_i[0]) begin
                rf[avs_address_i[3:2]] <= avs_writedata_i[7:0];
            end
        end
    end

    // sticky status, write one to clear; a setting event wins over the clear
    logic clr;
    logic fin;
    assign clr = acc & avs_write_i & (avs_address_i == OFS_STAT) & avs_byteenable_i[0];
    assign fin = (state == S_PAD) && (cyc == budget - 5'd1);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            done <= 1'b0;
            halted <= 1'b0;
            illegal <= 1'b0;
        end else begin
            done <= fin | (done & ~(clr & avs_writedata_i[STAT_DONE]));
            halted <= (fin & (ir0 == HALT_CODE)) // [RQ15]
                      | (halted & ~(clr & avs_writedata_i[STAT_HALT]));
            illegal <= (fin & ~legal & (ir0 != HALT_CODE))
                       | (illegal & ~(clr & avs_writedata_i[STAT_ILL]));
        end
    end
endmodule

// file: common/balex_pkg.sv
// constants, encodings and carriers shared by the byte arithmetic/logic execute unit
// assumes a single 40 MHz clock and a byte-wide program memory with one-cycle read latency
package balex_pkg;

    // clock and instruction timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_PER_MC = 3;
    localparam int MC_REG = 2;
    localparam int MC_REL = 3;
    localparam int MC_ABS = 4;
    localparam int MC_IND = 2;
    localparam logic [4:0] BUD_REG = 5'(MC_REG * CLK_PER_MC);
    localparam logic [4:0] BUD_REL = 5'(MC_REL * CLK_PER_MC);
    localparam logic [4:0] BUD_ABS = 5'(MC_ABS * CLK_PER_MC);
    localparam logic [4:0] BUD_IND = 5'(MC_IND * CLK_PER_MC);

    // register map, byte addresses
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_PC = 5'h08;
    localparam logic [4:0] OFS_PSW = 5'h0c;
    localparam logic [4:0] OFS_R0 = 5'h10;

    // field positions
    localparam int CTRL_GO = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_HALT = 2;
    localparam int STAT_ILL = 3;
    localparam int PSW_C = 0;
    localparam int PSW_OVF = 2;
    localparam int PSW_WC = 3;
    localparam int PSW_IDC = 5;
    localparam int PSW_CCLO = 6;
    localparam int PSW_CCHI = 7;

    // opcode layout: class in bits 7:4, addressing mode in 3:2, register in 1:0
    localparam logic [3:0] CLS_AND = 4'h4;
    localparam logic [3:0] CLS_IOR = 4'h6;
    localparam logic [3:0] CLS_ADD = 4'h8;
    localparam logic [3:0] CLS_SUB = 4'ha;
    localparam logic [1:0] MODE_Z = 2'h0;
    localparam logic [1:0] MODE_I = 2'h1;
    localparam logic [1:0] MODE_R = 2'h2;
    localparam logic [1:0] MODE_A = 2'h3;
    localparam logic [7:0] HALT_CODE = 8'h40;
    localparam int IND_BIT = 7;

    // condition code encodings
    localparam logic [1:0] CC_ZERO = 2'h0;
    localparam logic [1:0] CC_POS = 2'h1;
    localparam logic [1:0] CC_NEG = 2'h2;

    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [14:0] PC_RESET = 15'h0000;

    typedef enum logic [3:0] {
        OP_ADD = 4'b0001,
        OP_SUB = 4'b0010,
        OP_AND = 4'b0100,
        OP_IOR = 4'b1000
    } balex_op_t;

    typedef struct packed {
        logic [1:0] cc;
        logic interdigit_carry_flag;
        logic wc;
        logic ovf;
        logic c;
    } balex_flags_t;

    typedef struct packed {
        logic [7:0] data;
        balex_flags_t flags;
    } balex_res_t;

endpackage

// file: hw/balex_alu.sv
// combinational byte adder/subtractor and logic unit with flag generation
// assumes the caller latches the result and flags on its own clock
`timescale 1ns/10ps
module balex_alu import balex_pkg::*; (
    input wire balex_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire balex_flags_t flags_i,
    output balex_res_t res_o
);
    logic [7:0] b_eff;
    logic ci;
    logic [4:0] lo;
    logic [8:0] sum;
    logic [7:0] val;

    always_comb begin
        // subtraction adds the two's complement of the subtrahend [RQ6]
        b_eff = (op_i == OP_SUB) ? ~b_i : b_i;
        // with-carry mode feeds carry in as carry or as inverted borrow [RQ10] [RQ11]
        ci = flags_i.wc ? flags_i.c : (op_i == OP_SUB);
        lo = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, ci};
        sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, ci}; // plain binary adder [RQ1]
        res_o.flags = flags_i;
        unique case (op_i)
            OP_AND: val = a_i & b_i;
            OP_IOR: val = a_i | b_i;
            default: val = sum[7:0];
        endcase
        if (op_i == OP_ADD || op_i == OP_SUB) begin
            res_o.flags.c = sum[8]; // [RQ20]
            res_o.flags.interdigit_carry_flag = lo[4]; // [RQ20]
            res_o.flags.ovf = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]); // [RQ20]
        end
        // logic ops touch only the condition code [RQ13]
        if (val == 8'h00) begin
            res_o.flags.cc = CC_ZERO; // [RQ12]
        end else if (val[7]) begin
            res_o.flags.cc = CC_NEG; // [RQ12]
        end else begin
            res_o.flags.cc = CC_POS; // [RQ12]
        end
        res_o.data = val;
    end
endmodule

// file: bench/balex_core_assertions.sv
// checker for the execute unit: bus handshake and program memory fetch order
// assumes it is bound into balex_core and sees only that module's ports
`timescale 1ns/10ps
module balex_core_assertions import balex_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [14:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_data_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic go_take;
    logic legal;
    logic [4:0] since_go;
    logic [14:0] pc0;
    logic [7:0] op_q;
    logic [7:0] b1_q;
    assign go_take = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL
        && avs_writedata_i[CTRL_GO];
    assign legal = op_q[7:4] inside {CLS_AND, CLS_IOR, CLS_ADD, CLS_SUB};
    // saturates so an idle unit never looks like a fresh start
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            since_go <= 5'h1f;
        end else if (go_take) begin
            since_go <= 5'h01;
        end else if (since_go != 5'h1f) begin
            since_go <= since_go + 5'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (since_go == 5'h01) pc0 <= mem_addr_o;
        if (since_go == 5'h02) op_q <= mem_data_i;
        if (since_go == 5'h04) b1_q <= mem_data_i;
    end
    a_req_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered in its second cycle");
    a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high with no request");
    a_rdata_idle: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o))
        else $error("read data moved while idle");
    a_rd_pulse: assert property (mem_rd_o |=> !mem_rd_o) else $error("memory strobe too long");
    a_go_fetch: assert property (go_take |=> mem_rd_o) else $error("no opcode fetch after start");
    a_fetch_window: assert property (mem_rd_o |-> since_go >= 5'h01 && since_go <= 5'h12)
        else $error("memory read outside an instruction");
    a_byte1_next: assert property (since_go == 5'h03 && legal && op_q[3:2] != MODE_Z
        |-> mem_rd_o && mem_addr_o == pc0 + 15'h0001) else $error("second byte not fetched");
    a_rel_ea: assert property (since_go == 5'h05 && legal && op_q[3:2] == MODE_R && !b1_q[7]
        |-> ##[0:4] (mem_rd_o && mem_addr_o == pc0 + 15'h0002 + {{8{b1_q[6]}}, b1_q[6:0]}))
        else $error("relative operand address wrong");
    c_start: cover property (go_take);
    c_rel: cover property (since_go == 5'h05 && op_q[3:2] == MODE_R);
    c_abs_ind: cover property (since_go == 5'h06 && op_q[3:2] == MODE_A && b1_q[7]);
endmodule
bind balex_core balex_core_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i));

// file: bench/balex_prog_mem.sv
// program memory model: answers a one-cycle read strobe with the byte one clock later
// assumes the bench fills the array directly before each instruction
`timescale 1ns/10ps
module balex_prog_mem (
    input wire logic clk_i,
    input wire logic [14:0] mem_addr_i,
    input wire logic mem_rd_i,
    output logic [7:0] mem_data_o
);
    logic [7:0] mem [0:32767];
    logic valid;
    logic [14:0] addr_q;
    always_ff @(posedge clk_i) begin
        valid <= mem_rd_i;
        if (mem_rd_i) addr_q <= mem_addr_i;
    end
    // outside the answer cycle the byte is inverted so a late sample cannot pass by luck
    assign mem_data_o = valid ? mem[addr_q] : ~mem[addr_q];
endmodule

// file: bench/byte_arith_logic_execute_tb_top.sv
// self-checking bench for the execute unit: random operations in every form and class
// assumes the bound checker and the program memory model beside the design
`timescale 1ns/10ps
module byte_arith_logic_execute_tb_top import balex_pkg::*; ;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wreq;
    logic [14:0] maddr;
    logic mrd;
    logic [7:0] mdata;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    integer seed = 32'h9aeb;
    initial begin
        forever begin
            #12.5 clk = ~clk;
        end
    end
    balex_core DUT (.clk_i(clk), .resetn_i(resetn), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .mem_addr_o(maddr),
        .mem_rd_o(mrd), .mem_data_i(mdata));
    balex_prog_mem u_mem (.clk_i(clk), .mem_addr_i(maddr), .mem_rd_i(mrd), .mem_data_o(mdata));
    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // keep leaves the request up so a following access runs back to back
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic keep, output logic [31:0] q);
        adr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        if (!keep) begin
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic wr32(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 1'b0, q);
    endtask
    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] e, input logic keep);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, keep, q);
        chk(name, e, q & m);
    endtask
    // the first status read lands in the last busy cycle, the second two cycles after it
    task automatic exec(input logic [14:0] pc, input logic [4:0] bud);
        wr32(OFS_PC, {17'h0, pc});
        wr32(OFS_STAT, 32'he);
        wr32(OFS_CTRL, 32'h1);
        repeat (int'(bud) - 2) @(posedge clk);
        rd_chk("busy in last cycle", OFS_STAT, 32'h3, 32'h1, 1'b1);
        rd_chk("done after budget", OFS_STAT, 32'h3, 32'h2, 1'b0);
    endtask
    function automatic logic [15:0] ref_op(input logic [3:0] cls, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] psw);
        logic [7:0] bb;
        logic [7:0] r;
        logic [7:0] p;
        logic cin;
        logic [8:0] s;
        logic [4:0] h;
        p = psw;
        bb = (cls == CLS_SUB) ? ~b : b;
        cin = p[PSW_WC] ? p[PSW_C] : (cls == CLS_SUB);
        s = {1'b0, a} + {1'b0, bb} + 9'(cin);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(cin);
        r = (cls == CLS_AND) ? (a & b) : (cls == CLS_IOR) ? (a | b) : s[7:0];
        if (cls == CLS_ADD || cls == CLS_SUB) begin
            p[PSW_C] = s[8];
            p[PSW_IDC] = h[4];
            p[PSW_OVF] = (a[7] == bb[7]) && (r[7] != a[7]);
        end
        {p[PSW_CCHI], p[PSW_CCLO]} = (r == 8'h00) ? CC_ZERO : (r[7] ? CC_NEG : CC_POS);
        return {p, r};
    endfunction
    initial begin
        logic [7:0] regs [4];
        logic [15:0] cpair [4];
        logic [3:0] cls_tab [4];
        logic [3:0] cls;
        logic [1:0] mode, r, xsel;
        logic [7:0] a, b, v, b1, b2, psw;
        logic [6:0] disp;
        logic [14:0] pc, ea, tgt;
        logic [15:0] exp;
        logic [4:0] bud;
        logic ind;
        int dst;
        int len;
        cls_tab = '{CLS_AND, CLS_IOR, CLS_ADD, CLS_SUB};
        cpair = '{16'h7f01, 16'h8080, 16'h0000, 16'hff01};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            rd_chk("reset value", 5'(k * 4), 32'hffffffff, 32'h0, 1'b0);
        end
        for (int it = 0; it < 48; it++) begin
            cls = cls_tab[it % 4];
            mode = 2'((it / 4) % 4);
            r = 2'($random(seed));
            // opcode 0x40 is the halt, tried on its own below
            if (cls == CLS_AND && mode == MODE_Z && r == 2'h0) r = 2'h1;
            for (int k = 0; k < 4; k++) begin
                regs[k] = (it < 8) ? cpair[it % 4][15:8] : 8'($random(seed));
            end
            v = (it < 8) ? cpair[it % 4][7:0] : 8'($random(seed));
            psw = 8'($random(seed)) & 8'hed;
            pc = 15'h4000 | (15'($random(seed)) & 15'h00ff);
            ind = mode[1] && (($random(seed) & 3) == 0);
            xsel = 2'($random(seed));
            dst = r;
            a = regs[r];
            b = v;
            b1 = v;
            b2 = 8'h00;
            len = (mode == MODE_Z) ? 1 : (mode == MODE_A) ? 3 : 2;
            bud = (mode == MODE_A) ? BUD_ABS : (mode == MODE_R) ? BUD_REL : BUD_REG;
            if (mode == MODE_Z) begin
                dst = 0;
                a = regs[0];
                b = regs[r];
            end
            if (mode == MODE_R) begin
                disp = 7'($random(seed));
                // keeps the operand and pointer clear of the instruction bytes
                if (disp >= 7'h7d) disp = 7'h40;
                ea = pc + 15'h2 + {{8{disp[6]}}, disp};
                b1 = {ind, disp};
            end
            if (mode == MODE_A) begin
                ea = 15'($random(seed)) & 15'h1fff;
                b1 = {ind, xsel, ea[12:8]};
                b2 = ea[7:0];
            end
            if (ind) begin
                tgt = 15'h6000 | 15'($random(seed) & 8'hff);
                u_mem.mem[ea] = {1'($random(seed)), tgt[14:8]};
                u_mem.mem[ea + 15'h1] = tgt[7:0];
                ea = tgt;
                bud = bud + BUD_IND;
            end
            if (mode == MODE_A && xsel != 2'h0) begin
                ea = ea + 15'(regs[r]);
                dst = 0;
                a = regs[0];
            end
            if (mode[1]) u_mem.mem[ea] = v;
            u_mem.mem[pc] = {cls, mode, r};
            u_mem.mem[pc + 15'h1] = b1;
            if (mode == MODE_A) u_mem.mem[pc + 15'h2] = b2;
            for (int k = 0; k < 4; k++) begin
                wr32(OFS_R0 + 5'(k * 4), {24'h0, regs[k]});
            end
            wr32(OFS_PSW, {24'h0, psw});
            exec(pc, bud);
            exp = ref_op(cls, a, b, psw);
            regs[dst] = exp[7:0];
            for (int k = 0; k < 4; k++) begin
                rd_chk("register", OFS_R0 + 5'(k * 4), 32'hff, {24'h0, regs[k]}, 1'b0);
            end
            rd_chk("status word", OFS_PSW, 32'hed, {24'h0, exp[15:8]}, 1'b0);
            rd_chk("program counter", OFS_PC, 32'h7fff, {17'h0, pc + 15'(len)}, 1'b0);
        end
        u_mem.mem[15'h4200] = HALT_CODE;
        exec(15'h4200, BUD_REG);
        rd_chk("halt flag", OFS_STAT, 32'h4, 32'h4, 1'b0);
        rd_chk("r0 after halt", OFS_R0, 32'hff, {24'h0, regs[0]}, 1'b0);
        give_verdict();
    end
endmodule
